// ---- hw/ops_panel_status.sv ----
// Operator panel status register bank with APB slave and indicator drive
// Function
// - Hold a 16-bit basic status word of buttons, compares, errors, interrupt state.
// - Host can write status bits; pushbuttons also set some.
// - Bits 0-2 encode last selection pushbutton, 000 none to 111 address control.
// - Invalid host command raises system check; lights panel check when panel entry enabled (control bit 3).
// - Clear-panel pushbutton extinguishes the panel check indicator.
// - Locked keypad ignores its pushbuttons and lights keyboard-locked indicator.
// - Keypad digits shift into the currently selected 32-bit panel register.
// - Translation indicator lit under logical addressing, dark under real.
// - Light one of four mode indicators matching processor execution mode.
// - Vector indicator lit for primary vector, dark for secondary.
// - Level display shows current level, or last level while button held.
// - Start or stop with panel enabled requests level 0 and records button.
// - Separate indicators for compare fetch, compare store, check stop, processor stopped.
// - Bit 15 set by bits 4,5,6,8,9,10,12,13; with bit 14 interrupts, blocks buttons.
// - Bit 14 is software set/cleared, cleared by control reset; off blocks interrupt.
// - Control bit 7 locks all but five buttons; set by stop conditions or errors.
// - Control bit 4 selects register 2, else register 1, and drives register lamps.
`timescale 1ns/1ps
module ops_panel_status
    import ops_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ops_buttons_s buttons,
    input wire ops_proc_s proc,
    output ops_lamps_s lamps,
    output logic systemCheck,
    output logic level0Request
);
    logic [15:0] status_q, status_d;
    logic [7:0] control_q, control_d;
    logic [31:0] reg1_q, reg1_d, reg2_q, reg2_d;
    logic panelCheck_q;
    logic sysCheck_q;
    logic irq_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    ops_buttons_s btnPrev_q;
    ops_lamps_s lamps_q, lamps_d;

    // Bus decode
    wire logic setupPhase = psel & ~penable;
    wire logic busDone = psel & penable & pready_q;
    wire logic [7:0] offs = paddr[OPS_AW-1:0];
    wire logic inRange = (paddr[31:OPS_AW] == '0) & (paddr[1:0] == 2'h0);
    wire logic hitStatus = inRange & (offs == OPS_OFS_STATUS);
    wire logic hitControl = inRange & (offs == OPS_OFS_CONTROL);
    wire logic hitReg1 = inRange & (offs == OPS_OFS_REG1);
    wire logic hitReg2 = inRange & (offs == OPS_OFS_REG2);
    wire logic hitCommand = inRange & (offs == OPS_OFS_COMMAND);
    wire logic hitProc = inRange & (offs == OPS_OFS_PROC);
    wire logic mapped = hitStatus | hitControl | hitReg1 | hitReg2 | hitCommand | hitProc;
    wire logic wrDone = busDone & pwrite & mapped;
    wire logic wrStatus = wrDone & hitStatus;
    wire logic wrControl = wrDone & hitControl;
    wire logic wrReg1 = wrDone & hitReg1;
    wire logic wrReg2 = wrDone & hitReg2;
    wire logic wrCommand = wrDone & hitCommand;

    // Commands
    wire logic [7:0] cmdCode = pwdata[7:0];
    wire logic cmdResetCtl = wrCommand & (cmdCode == CMD_RESET_CONTROL);
    wire logic cmdResetSt = wrCommand & (cmdCode == CMD_RESET_STATUS);
    wire logic cmdResetDev = wrCommand & (cmdCode == CMD_RESET_DEVICE);
    wire logic cmdInvalid = wrCommand & ~(cmdResetCtl | cmdResetSt | cmdResetDev);

    // Edge detection: one press gives one pulse
    wire ops_buttons_s rise = buttons & ~btnPrev_q;
    wire logic keyRise = buttons.keyStrobe & ~btnPrev_q.keyStrobe;

    // Button gating; while interrupt pending only enable/disable and last level work
    wire logic irqBlock = status_q[ST_IRQ] & status_q[ST_ENABLE];
    wire logic locked = control_q[CT_KEY_LOCK];
    wire logic entryEn = control_q[CT_ENTRY_EN];
    wire logic btnOpen = entryEn & ~irqBlock;
    wire logic lockedOpen = btnOpen & ~locked;
    // Five buttons survive the lock: start, stop, enable, clear, last level
    wire logic startPress = btnOpen & rise.actBtn[ACT_START];
    wire logic stopPress = btnOpen & rise.actBtn[ACT_STOP];
    wire logic clearPress = btnOpen & rise.clearPanelBtn;
    wire logic enablePress = rise.enableBtn;
    wire logic [7:0] actLive = lockedOpen ? rise.actBtn : 8'h00;
    wire logic [7:0] selLive = lockedOpen ? rise.selBtn : 8'h00;
    wire logic keyLive = lockedOpen & keyRise;

    // Priority encoders, highest index wins on a simultaneous press
    logic [2:0] selCode, actCode;
    always_comb
    begin
        selCode = 3'h0;
        actCode = 3'h0;
        for (int i = 1; i < 8; i++)
        begin
            if (selLive[i])
                selCode = 3'(i);
            if (actLive[i])
                actCode = 3'(i);
        end
    end
    wire logic anySel = |selLive[7:1];
    wire logic anyAct = |actLive | startPress | stopPress;
    wire logic [2:0] actFinal = stopPress ? ACT_STOP : (startPress ? ACT_START : actCode);

    // Stop conditions from the processor and from an invalid host command
    wire logic hitFetch = proc.cmpFetchHit & control_q[CT_STOP_FETCH];
    wire logic hitStore = proc.cmpStoreHit & control_q[CT_STOP_STORE];
    wire logic hitCheck = (proc.checkEvent | cmdInvalid) & control_q[CT_STOP_CHECK];
    wire logic stopCond = hitFetch | hitStore | hitCheck;

    // Status next value: hardware sets win over a same-cycle software write
    logic [15:0] stSet, stBase;
    always_comb
    begin
        stBase = status_q;
        if (wrStatus)
            stBase = pwdata[15:0];
        if (cmdResetSt | cmdResetDev)
            stBase = OPS_STATUS_RST;
        if (cmdResetCtl)
            stBase[ST_ENABLE] = 1'b0;
        if (anySel)
            stBase[ST_SEL_HI:ST_SEL_LO] = selCode;
        if (anyAct)
            stBase[ST_ACT_HI:ST_ACT_LO] = actFinal;
        stSet = '0;
        stSet[ST_XFORM] = lockedOpen & rise.transformBtn;
        stSet[ST_CMP_FETCH] = hitFetch;
        stSet[ST_CMP_STORE] = hitStore;
        stSet[ST_CHK_STOP] = hitCheck;
        stSet[ST_STOP_COND] = stopCond;
        stSet[ST_EQUIP] = cmdInvalid;
        stSet[ST_INIT] = enablePress & ~status_q[ST_INIT];
        status_d = stBase | stSet;
        if (|(status_d & ST_IRQ_SRC))
            status_d[ST_IRQ] = 1'b1;
    end

    // Control next value
    always_comb
    begin
        control_d = control_q;
        if (wrControl)
            control_d = pwdata[7:0];
        if (cmdResetCtl | cmdResetDev)
            control_d = OPS_CONTROL_RST;
        if (enablePress)
            control_d[CT_ENTRY_EN] = ~control_q[CT_ENTRY_EN];
        if (lockedOpen & rise.accessReg2Btn)
            control_d[CT_ACCESS_R2] = 1'b1;
        if (lockedOpen & rise.accessReg1Btn)
            control_d[CT_ACCESS_R2] = 1'b0;
        if (clearPress)
        begin
            control_d[CT_ACCESS_R2] = 1'b0;
            control_d[CT_ATTN] = 1'b0;
        end
        if (stopCond | stopPress)
            control_d[CT_STOPPED] = 1'b1;
        // A system check locks the keypad even when stop on check is off
        if (stopCond | proc.panelError | proc.checkEvent | cmdInvalid)
            control_d[CT_KEY_LOCK] = 1'b1;
    end

    // Panel registers: a digit enters the units end and shifts left
    wire logic [31:0] reg1Shift = {reg1_q[31-OPS_DIGIT_W:0], buttons.keyDigit};
    wire logic [31:0] reg2Shift = {reg2_q[31-OPS_DIGIT_W:0], buttons.keyDigit};
    wire logic selR2 = control_q[CT_ACCESS_R2];
    always_comb
    begin
        reg1_d = wrReg1 ? pwdata : reg1_q;
        reg2_d = wrReg2 ? pwdata : reg2_q;
        if (keyLive & ~selR2)
            reg1_d = reg1Shift;
        if (keyLive & selR2)
            reg2_d = reg2Shift;
        if (clearPress | cmdResetDev)
        begin
            reg1_d = '0;
            reg2_d = '0;
        end
    end

    // Indicators
    always_comb
    begin
        lamps_d = '0;
        // A new check wins over a clear in the same cycle, so no check is lost
        lamps_d.panelCheck = (panelCheck_q & ~clearPress) | (cmdInvalid & entryEn);
        lamps_d.keyboardLocked = control_d[CT_KEY_LOCK];
        lamps_d.translationActive = proc.logicalAddr;
        lamps_d.modeLamps = 4'(4'h1 << proc.progMode);
        lamps_d.psvPrimary = proc.primaryPsv;
        lamps_d.levelDisplay = buttons.lastLevelBtn ? proc.lastLevel : proc.curLevel;
        lamps_d.stopFetch = control_d[CT_STOP_FETCH];
        lamps_d.stopStore = control_d[CT_STOP_STORE];
        lamps_d.stopCheck = control_d[CT_STOP_CHECK];
        lamps_d.procStopped = control_d[CT_STOPPED];
        lamps_d.reg1Lamp = ~control_d[CT_ACCESS_R2];
        lamps_d.reg2Lamp = control_d[CT_ACCESS_R2];
        lamps_d.attention = control_d[CT_ATTN];
    end

    // Read mux; registered at setup so prdata is a flop
    logic [31:0] rdMux;
    always_comb
    begin
        rdMux = '0;
        if (hitStatus)
            rdMux = {16'h0000, status_q};
        if (hitControl)
            rdMux = {24'h000000, control_q};
        if (hitReg1)
            rdMux = reg1_q;
        if (hitReg2)
            rdMux = reg2_q;
        if (hitProc)
            rdMux = {20'h00000, proc.primaryPsv, proc.logicalAddr, proc.progMode,
                     proc.lastLevel, proc.curLevel};
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end
        else
        begin
            pready_q <= setupPhase;
            pslverr_q <= setupPhase & ~mapped;
            if (setupPhase)
                prdata_q <= pwrite ? 32'h0000_0000 : rdMux;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            status_q <= OPS_STATUS_RST;
            control_q <= OPS_CONTROL_RST;
            reg1_q <= '0;
            reg2_q <= '0;
            panelCheck_q <= 1'b0;
            sysCheck_q <= 1'b0;
            irq_q <= 1'b0;
            btnPrev_q <= '0;
            lamps_q <= '0;
        end
        else
        begin
            status_q <= status_d;
            control_q <= control_d;
            reg1_q <= reg1_d;
            reg2_q <= reg2_d;
            panelCheck_q <= lamps_d.panelCheck;
            sysCheck_q <= cmdInvalid;
            irq_q <= status_d[ST_IRQ] & status_d[ST_ENABLE];
            btnPrev_q <= buttons;
            lamps_q <= lamps_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign lamps = lamps_q;
    assign systemCheck = sysCheck_q;
    assign level0Request = irq_q;

    // Checks; lamp checks skip the first edge after reset, where lamps hold reset values
    a_invalid_syscheck: assert property (@(posedge sys_clk) disable iff (!reset_n)
        cmdInvalid |=> systemCheck && status_q[ST_EQUIP])
        else $error("invalid command without system check");
    a_check_lamp_lit: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (cmdInvalid && entryEn) |=> lamps.panelCheck)
        else $error("panel check not lit by invalid command");
    a_clear_check_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (clearPress && !cmdInvalid) |=> !lamps.panelCheck)
        else $error("panel check survived clear panel");
    a_lock_no_key: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (locked && keyRise && !wrReg1 && !wrReg2 && !clearPress && !cmdResetDev && !wrControl
        && !cmdResetCtl) |=> $stable(reg1_q) && $stable(reg2_q) && lamps.keyboardLocked)
        else $error("locked keypad changed state");
    a_trans_psv_lamp: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $past(reset_n) |-> lamps.translationActive == $past(proc.logicalAddr)
        && lamps.psvPrimary == $past(proc.primaryPsv))
        else $error("translation or vector lamp wrong");
    a_mode_onehot: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $past(reset_n) |-> $onehot(lamps.modeLamps))
        else $error("mode lamps not one-hot");
    a_level_shown: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $past(reset_n) |-> lamps.levelDisplay == ($past(buttons.lastLevelBtn)
        ? $past(proc.lastLevel) : $past(proc.curLevel)))
        else $error("level display wrong");
    a_key_shift_reg: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (keyLive && !selR2 && !clearPress && !cmdResetDev) |=> reg1_q[3:0] == $past(buttons.keyDigit))
        else $error("keypad digit not entered");
    a_irq_needs_enable: assert property (@(posedge sys_clk) disable iff (!reset_n)
        level0Request == (status_q[ST_ENABLE] && status_q[ST_IRQ]))
        else $error("interrupt while panel disabled");
    a_blocked_no_sel: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (irqBlock && !wrStatus && !cmdResetSt && !cmdResetDev)
        |=> $stable(status_q[ST_SEL_HI:ST_SEL_LO]))
        else $error("selection accepted while interrupt pending");
    a_irq_bit_source: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (status_q & ST_IRQ_SRC) != 16'h0000 |-> status_q[ST_IRQ])
        else $error("interrupt bit missing");
    a_start_records: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (startPress && !stopPress) |=> status_q[ST_ACT_HI:ST_ACT_LO] == ACT_START ##1
        (!status_q[ST_ENABLE] || level0Request))
        else $error("start press not recorded");
    a_stop_locks: assert property (@(posedge sys_clk) disable iff (!reset_n)
        stopCond |=> control_q[CT_KEY_LOCK] && control_q[CT_STOPPED] ##1 lamps.keyboardLocked)
        else $error("stop condition did not lock keypad");
    a_check_locks: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (cmdInvalid || proc.checkEvent) |=> control_q[CT_KEY_LOCK])
        else $error("system check did not lock keypad");
    a_reg_lamp_sel: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $past(reset_n) |-> lamps.reg2Lamp == control_q[CT_ACCESS_R2]
        && lamps.reg1Lamp != lamps.reg2Lamp)
        else $error("register lamps wrong");
    c_start_irq: cover property (@(posedge sys_clk) disable iff (!reset_n)
        startPress ##[1:3] level0Request);
    c_invalid_cmd: cover property (@(posedge sys_clk) disable iff (!reset_n) cmdInvalid);
    c_key_entry: cover property (@(posedge sys_clk) disable iff (!reset_n) keyLive && selR2);
    c_lock_refused: cover property (@(posedge sys_clk) disable iff (!reset_n) locked && keyRise);
    c_blocked_enable: cover property (@(posedge sys_clk) disable iff (!reset_n)
        irqBlock && enablePress);
endmodule // ops_panel_status

// ---- hw/ops_pkg.sv ----
// Constants, field layout and carriers for the operator panel status block
package ops_pkg;
    localparam int OPS_AW = 8;
    localparam logic [7:0] OPS_OFS_STATUS = 8'h00;
    localparam logic [7:0] OPS_OFS_CONTROL = 8'h04;
    localparam logic [7:0] OPS_OFS_REG1 = 8'h08;
    localparam logic [7:0] OPS_OFS_REG2 = 8'h0C;
    localparam logic [7:0] OPS_OFS_COMMAND = 8'h10;
    localparam logic [7:0] OPS_OFS_PROC = 8'h14;
    localparam logic [15:0] OPS_STATUS_RST = 16'h0000;
    localparam logic [7:0] OPS_CONTROL_RST = 8'h00;
    // Basic status fields
    localparam int ST_SEL_LO = 0;
    localparam int ST_SEL_HI = 2;
    localparam int ST_XFORM = 3;
    localparam int ST_CMP_FETCH = 4;
    localparam int ST_CMP_STORE = 5;
    localparam int ST_CHK_STOP = 6;
    localparam int ST_ACT_LO = 8;
    localparam int ST_ACT_HI = 10;
    localparam int ST_INIT = 11;
    localparam int ST_STOP_COND = 12;
    localparam int ST_EQUIP = 13;
    localparam int ST_ENABLE = 14;
    localparam int ST_IRQ = 15;
    localparam logic [15:0] ST_IRQ_SRC = 16'h3770;
    // Control register fields
    localparam int CT_STOP_FETCH = 0;
    localparam int CT_STOP_STORE = 1;
    localparam int CT_STOP_CHECK = 2;
    localparam int CT_ENTRY_EN = 3;
    localparam int CT_ACCESS_R2 = 4;
    localparam int CT_STOPPED = 5;
    localparam int CT_ATTN = 6;
    localparam int CT_KEY_LOCK = 7;
    // Action codes
    localparam logic [2:0] ACT_START = 3'h3;
    localparam logic [2:0] ACT_STOP = 3'h6;
    // Commands
    localparam logic [7:0] CMD_RESET_CONTROL = 8'h01;
    localparam logic [7:0] CMD_RESET_STATUS = 8'h02;
    localparam logic [7:0] CMD_RESET_DEVICE = 8'h03;
    localparam logic [3:0] OPS_DIGIT_W = 4'h4;

    typedef struct packed {
        logic [7:0] selBtn;
        logic [7:0] actBtn;
        logic transformBtn;
        logic enableBtn;
        logic clearPanelBtn;
        logic lastLevelBtn;
        logic accessReg1Btn;
        logic accessReg2Btn;
        logic keyStrobe;
        logic [3:0] keyDigit;
    } ops_buttons_s;

    typedef struct packed {
        logic [3:0] curLevel;
        logic [3:0] lastLevel;
        logic [1:0] progMode;
        logic logicalAddr;
        logic primaryPsv;
        logic cmpFetchHit;
        logic cmpStoreHit;
        logic checkEvent;
        logic panelError;
    } ops_proc_s;

    typedef struct packed {
        logic panelCheck;
        logic keyboardLocked;
        logic translationActive;
        logic [3:0] modeLamps;
        logic psvPrimary;
        logic [3:0] levelDisplay;
        logic stopFetch;
        logic stopStore;
        logic stopCheck;
        logic procStopped;
        logic reg1Lamp;
        logic reg2Lamp;
        logic attention;
    } ops_lamps_s;
endpackage

// ---- test/ops_proc_model.sv ----
// Processor-side model driving level, mode and event lines into the panel
`timescale 1ns/1ps
module ops_proc_model
    import ops_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    output ops_proc_s proc
);
    initial proc = '0;

    // Level, mode, addressing and vector state are held until changed
    task set_state(input logic [3:0] cur, input logic [3:0] last, input logic [1:0] mode,
        input logic logical, input logic primary);
        @(posedge sys_clk);
        proc.curLevel <= cur;
        proc.lastLevel <= last;
        proc.progMode <= mode;
        proc.logicalAddr <= logical;
        proc.primaryPsv <= primary;
    endtask

    // Events last one cycle: 0 fetch hit, 1 store hit, 2 check, 3 panel error
    task pulse_event(input int idx);
        @(posedge sys_clk);
        proc[3:0] <= reset_n ? (4'h8 >> idx) : 4'h0;
        @(posedge sys_clk);
        proc[3:0] <= 4'h0;
    endtask
endmodule // ops_proc_model

// ---- test/tb_top.sv ----
// Self-checking bench for the operator panel status block
`timescale 1ns/1ps
module tb_top
    import ops_pkg::*;
;
    logic sys_clk;
    logic reset_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    ops_buttons_s btn;
    ops_proc_s proc;
    ops_lamps_s lamps;
    logic systemCheck;
    logic level0Request;
    logic [31:0] rdData;
    logic rdErr;
    int n_errors = 0;
    int cmp_count = 0;
    int scCount = 0;
    int actOrder[7] = '{1, 2, 3, 4, 5, 7, 6};

    ops_panel_status u_ops_panel_status (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .buttons(btn), .proc(proc), .lamps(lamps),
        .systemCheck(systemCheck), .level0Request(level0Request));
    ops_proc_model u_ops_proc_model (.sys_clk(sys_clk), .reset_n(reset_n), .proc(proc));

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
        if (systemCheck === 1'b1) scCount <= scCount + 1;

    task end_of_test;
        if (n_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Request held from setup until pready is seen high; no wait count assumed
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        paddr <= {24'h0, a};
        pwrite <= wr;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rdData = prdata;
        rdErr = pslverr;
        if (n >= 16)
        begin
            n_errors++;
            end_of_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    // Kind 0 selection, 1 action, 2 key digit, 4 enable, otherwise clear panel
    task press(input int kind, input int idx);
        ops_buttons_s b;
        b = '0;
        case (kind)
            0: b.selBtn = 8'h01 << idx;
            1: b.actBtn = 8'h01 << idx;
            2: b[4:0] = {1'b1, 4'(idx)};
            4: b.enableBtn = 1'b1;
            default: b.clearPanelBtn = 1'b1;
        endcase
        @(posedge sys_clk);
        btn <= b;
        repeat (3) @(posedge sys_clk);
        btn <= '0;
        repeat (3) @(posedge sys_clk);
    endtask

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        end_of_test();
    end

    initial
    begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        btn = '0;
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check(32'(lamps.reg1Lamp), 32'h1);
        rd(OPS_OFS_STATUS);
        check(rdData, 32'h0);
        rd(OPS_OFS_CONTROL);
        check(rdData, 32'h0);
        rd(8'h18);
        check({rdData[30:0], rdErr}, 32'h1);
        wr(OPS_OFS_CONTROL, 32'h8);
        for (int i = 1; i < 8; i++)
        begin
            press(0, i);
            rd(OPS_OFS_STATUS);
            check(rdData & 32'h7, 32'(i));
        end
        foreach (actOrder[k])
        begin
            press(1, actOrder[k]);
            rd(OPS_OFS_STATUS);
            check(rdData & 32'h8700, 32'h8000 | (32'(actOrder[k]) << 8));
        end
        check(32'(level0Request), 32'h0);
        wr(OPS_OFS_STATUS, 32'h4000);
        wr(OPS_OFS_COMMAND, 32'(CMD_RESET_CONTROL));
        rd(OPS_OFS_CONTROL);
        check(rdData, 32'h0);
        rd(OPS_OFS_STATUS);
        check(rdData & 32'h4000, 32'h0);
        wr(OPS_OFS_COMMAND, 32'(CMD_RESET_STATUS));
        rd(OPS_OFS_STATUS);
        check(rdData, 32'h0);
        check(32'(scCount), 32'h0);
        wr(OPS_OFS_CONTROL, 32'h8);
        wr(OPS_OFS_STATUS, 32'h4000);
        check(32'(level0Request), 32'h0);
        press(1, 3);
        rd(OPS_OFS_STATUS);
        check(rdData & 32'hC700, 32'hC300);
        check(32'(level0Request), 32'h1);
        press(0, 2);
        rd(OPS_OFS_STATUS);
        check(rdData & 32'h7, 32'h0);
        wr(OPS_OFS_STATUS, 32'h0);
        repeat (3) @(posedge sys_clk);
        check(32'(level0Request), 32'h0);
        for (int i = 1; i < 4; i++) press(2, i);
        rd(OPS_OFS_REG1);
        check(rdData, 32'h123);
        wr(OPS_OFS_CONTROL, 32'h18);
        press(2, 10);
        press(2, 11);
        rd(OPS_OFS_REG2);
        check(rdData, 32'hAB);
        check(32'({lamps.reg1Lamp, lamps.reg2Lamp}), 32'h1);
        wr(OPS_OFS_CONTROL, 32'h88);
        press(2, 5);
        rd(OPS_OFS_REG1);
        check(rdData, 32'h123);
        check(32'(lamps.keyboardLocked), 32'h1);
        wr(OPS_OFS_CONTROL, 32'h8);
        wr(OPS_OFS_COMMAND, 32'hFF);
        repeat (3) @(posedge sys_clk);
        check(32'(scCount), 32'h1);
        check(32'(lamps.panelCheck), 32'h1);
        check(32'(lamps.keyboardLocked), 32'h1);
        rd(OPS_OFS_STATUS);
        check(rdData & 32'hA000, 32'hA000);
        press(3, 0);
        check(32'(lamps.panelCheck), 32'h0);
        rd(OPS_OFS_REG1);
        check(rdData, 32'h0);
        wr(OPS_OFS_CONTROL, 32'h2F);
        repeat (3) @(posedge sys_clk);
        check(32'({lamps.stopFetch, lamps.stopStore, lamps.stopCheck, lamps.procStopped}),
            32'hF);
        for (int m = 0; m < 4; m++)
        begin
            u_ops_proc_model.set_state(4'h5, 4'h2, 2'(m), 1'b1, 1'b1);
            repeat (4) @(posedge sys_clk);
            check(32'(lamps.modeLamps), 32'h1 << m);
        end
        check(32'(lamps.translationActive), 32'h1);
        check(32'(lamps.psvPrimary), 32'h1);
        check(32'(lamps.levelDisplay), 32'h5);
        btn <= '{lastLevelBtn: 1'b1, default: '0};
        repeat (4) @(posedge sys_clk);
        check(32'(lamps.levelDisplay), 32'h2);
        btn <= '0;
        u_ops_proc_model.set_state(4'h5, 4'h2, 2'h0, 1'b0, 1'b0);
        repeat (4) @(posedge sys_clk);
        check(32'({lamps.translationActive, lamps.psvPrimary}), 32'h0);
        wr(OPS_OFS_STATUS, 32'h0);
        u_ops_proc_model.pulse_event(0);
        repeat (3) @(posedge sys_clk);
        rd(OPS_OFS_STATUS);
        check(rdData & 32'h8010, 32'h8010);
        wr(OPS_OFS_REG2, 32'h55);
        wr(OPS_OFS_COMMAND, 32'(CMD_RESET_DEVICE));
        rd(OPS_OFS_REG2);
        check(rdData, 32'h0);
        rd(OPS_OFS_CONTROL);
        check(rdData, 32'h0);
        wr(OPS_OFS_CONTROL, 32'h8);
        wr(OPS_OFS_STATUS, 32'h4000);
        press(1, 6);
        check(32'(level0Request), 32'h1);
        press(4, 0);
        rd(OPS_OFS_CONTROL);
        check(rdData & 32'h28, 32'h20);
        end_of_test();
    end
endmodule // tb_top
